/* File: rtl/wml_debounce.sv */
// Rain-gauge contact debouncer: one pulse per closure.
// Assumes the contact input is asynchronous and active low when closed.
`timescale 1ns/10ps
`include "wml_defines.svh"
module wml_debounce #(
   parameter int HOLD_CYC = `WML_DEBOUNCE_CYC
) (
   input  wire logic sys_clk_i,   // System clock.
   input  wire logic srst_i,      // Synchronous reset.
   input  wire logic contact_n_i, // Gauge contact, low when closed.
   output logic      pulse_o      // One-cycle count pulse.
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   logic [2:0]    sync_ff;
   logic          closed_ff;
   logic [CW-1:0] cnt_ff;
   logic          pulse_ff;
   logic          agree;
   // A zero hold time would leave the counter compare unreachable, so refuse it.
   if (HOLD_CYC < 1)
   begin : g_bad_hold
      $error("HOLD_CYC must be at least one");
   end
   // Three-stage synchroniser; only the last two are compared.
   always_ff @(posedge sys_clk_i)
      if (srst_i) sync_ff <= 3'h7;
      else sync_ff <= {sync_ff[1:0], contact_n_i};
   assign agree = (sync_ff[2] == sync_ff[1]);
   // A state change is accepted only after the input stays put, so bounce is ignored.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         closed_ff <= 1'b0;
         cnt_ff    <= '0;
         pulse_ff  <= 1'b0;
      end
      else
      begin
         pulse_ff <= 1'b0;
         if (!agree || (sync_ff[2] == ~closed_ff)) cnt_ff <= '0;
         else if (cnt_ff == CW'(HOLD_CYC - 1))
         begin
            cnt_ff    <= '0;
            closed_ff <= ~closed_ff;
            pulse_ff  <= closed_ff ? 1'b0 : 1'b1;
         end
         else cnt_ff <= cnt_ff + 1'b1;
      end
   end
   assign pulse_o = pulse_ff;
   // One pulse only when a closure is newly accepted.
   pulse_close_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pulse_ff |-> closed_ff && !$past(closed_ff))
      else $error("count pulse without new closure");
endmodule

/* File: rtl/wml_defines.svh */
// Constants for the weather monitor logic: address blocks, codes, timing.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef WML_DEFINES_SVH
`define WML_DEFINES_SVH
`define WML_BLK_ANA0        5'h00
`define WML_BLK_ANA1        5'h01
`define WML_BLK_ANA2        5'h02
`define WML_BLK_MON         5'h03
`define WML_BLK_CMD         5'h04
`define WML_MON_IDENT       3'h0
`define WML_MON_SERIAL      3'h4
`define WML_MON_WIND        3'h6
`define WML_MON_RAIN        3'h7
`define WML_CMD_PEAK_CLR    3'h3
`define WML_CMD_RAIN_CLR    3'h4
`define WML_TYPE_CODE       8'h5a
`define WML_CLK_NS          100
`define WML_DEBOUNCE_NS     2000000
`define WML_DEBOUNCE_CYC    (`WML_DEBOUNCE_NS / `WML_CLK_NS)
`endif

/* File: rtl/wml_pkg.sv */
// Types shared by the weather monitor logic.
// Assumes nothing beyond a SystemVerilog compiler.
package wml_pkg;
   // One host request: relative address, direction, strobe.
   typedef struct packed {
      logic       req;
      logic       rd;
      logic [7:0] addr;
   } wml_req_t;
   // Analog multiplexer selection toward the host board.
   typedef struct packed {
      logic       en_one;
      logic       en_two;
      logic [2:0] chan;
   } wml_mux_t;
endpackage

/* File: rtl/wml_top.sv */
// Weather monitor logic: address decode, identity, wind peak, rain count.
// Assumes the host board drives request, address and read/write synchronously.
// Contract
// - Serial from link header, cut link reads one.
// - Fixed type code returned on identity read.
// - Wind word: speed low byte, peak high.
// - New conversion keeps the greater as peak.
// - Peak reset command clears the peak.
// - Debounced closures advance counter, read back.
// - Each count means a tenth millimetre.
// - Rain reset command clears the rain counter.
// - Analog enable for first three blocks.
// - Bank select routes blocks two, three on-board.
// - Acknowledge monitor block reads and command block writes.
// - Monitor decode only for block four reads.
// - Two multiplexers select from low address bits.
// - First multiplexer enabled by second block.
// - Second multiplexer enabled by third block.
`timescale 1ns/10ps
`include "wml_defines.svh"
module wml_top #(
   parameter int          DEBOUNCE_CYC = `WML_DEBOUNCE_CYC,
   parameter logic [7:0]  TYPE_CODE    = `WML_TYPE_CODE // Arbitrary value.
) (
   input  wire logic             sys_clk_i,        // System clock, 10 MHz.
   input  wire logic             srst_i,           // Synchronous reset.
   input  wire wml_pkg::wml_req_t req_i,           // Host request.
   input  wire logic [7:0]       serial_link_header_i, // Links, pulled up.
   input  wire logic [7:0]       wind_speed_i,     // Converter result.
   input  wire logic             wind_valid_i,     // Conversion done pulse.
   input  wire logic             rain_contact_n_i, // Gauge contact.
   output logic [15:0]           mon_data_o,       // Monitor data.
   output logic                  analog_sample_enable_o, // Analog range.
   output logic                  bank_select_o,    // On-board mux bank.
   output logic                  device_acknowledge_o, // Request taken.
   output wml_pkg::wml_mux_t     mux_o,            // Mux enables and channel.
   output logic                  peak_clr_o,       // Peak cleared pulse.
   output logic                  rain_clr_o        // Rain cleared pulse.
);
   logic [2:0]  hdr_ff [8];
   logic [7:0]  serial_ff;
   logic [7:0]  peak_ff;
   logic [7:0]  speed_ff;
   logic [15:0] rain_ff;
   logic [15:0] data_ff;
   logic        ana_ff;
   logic        bank_ff;
   logic        ack_ff;
   logic        pclr_ff;
   logic        rclr_ff;
   wml_pkg::wml_mux_t mux_ff;
   logic [4:0]  blk;
   logic [2:0]  sub;
   logic        mon_rd;
   logic        cmd_wr;
   logic        rain_pulse;

   // The debouncer cannot count a hold time below one cycle.
   if (DEBOUNCE_CYC < 1)
   begin : g_bad_deb
      $error("DEBOUNCE_CYC must be positive");
   end

   assign blk    = req_i.addr[7:3];
   assign sub    = req_i.addr[2:0];
   // Monitor decode needs block four and a read; commands need block five and a write.
   assign mon_rd = req_i.req && req_i.rd && (blk == `WML_BLK_MON);
   assign cmd_wr = req_i.req && !req_i.rd && (blk == `WML_BLK_CMD);

   wml_debounce #(
      .HOLD_CYC    (DEBOUNCE_CYC)
   ) u_deb (
      .sys_clk_i   (sys_clk_i),
      .srst_i      (srst_i),
      .contact_n_i (rain_contact_n_i),
      .pulse_o     (rain_pulse)
   );

   // Link header is static straps; synchronise each bit anyway.
   genvar g;
   for (g = 0; g < 8; g++)
   begin : g_hdr
      always_ff @(posedge sys_clk_i)
         if (srst_i) hdr_ff[g] <= 3'h7;
         else hdr_ff[g] <= {hdr_ff[g][1:0], serial_link_header_i[g]};
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i) serial_ff <= 8'hff;
      else
         for (int i = 0; i < 8; i++)
            if (hdr_ff[i][2] == hdr_ff[i][1]) serial_ff[i] <= hdr_ff[i][2];
   end

   // Peak hold; a clear command wins unless a sample arrives in the same cycle, which then becomes the peak.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         peak_ff  <= 8'h00;
         speed_ff <= 8'h00;
      end
      else
      begin
         if (wind_valid_i) speed_ff <= wind_speed_i;
         if (wind_valid_i && (cmd_wr && sub == `WML_CMD_PEAK_CLR))
            peak_ff <= wind_speed_i;
         else if (cmd_wr && sub == `WML_CMD_PEAK_CLR) peak_ff <= 8'h00;
         else if (wind_valid_i && wind_speed_i > peak_ff) peak_ff <= wind_speed_i;
      end
   end

   // Rain counter in tenths of a millimetre; a count in the clear cycle survives.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i) rain_ff <= 16'h0000;
      else if (cmd_wr && sub == `WML_CMD_RAIN_CLR)
         rain_ff <= {15'h0000, rain_pulse};
      else if (rain_pulse) rain_ff <= rain_ff + 16'h0001;
   end

   // Monitor read mux, held until the next monitor read.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i) data_ff <= 16'h0000;
      else if (mon_rd)
      begin
         case (sub)
            `WML_MON_IDENT:  data_ff <= {8'h00, TYPE_CODE};
            `WML_MON_SERIAL: data_ff <= {8'h00, serial_ff};
            `WML_MON_WIND:   data_ff <= {peak_ff, speed_ff};
            `WML_MON_RAIN:   data_ff <= rain_ff;
            default:         data_ff <= 16'h0000;
         endcase
      end
   end

   // Block decode outputs, registered one cycle after the request.
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         ana_ff  <= 1'b0;
         bank_ff <= 1'b0;
         ack_ff  <= 1'b0;
         pclr_ff <= 1'b0;
         rclr_ff <= 1'b0;
         mux_ff  <= '0;
      end
      else
      begin
         ana_ff  <= req_i.req && (blk <= `WML_BLK_ANA2);
         bank_ff <= req_i.req && (blk == `WML_BLK_ANA1 || blk == `WML_BLK_ANA2);
         ack_ff  <= mon_rd || cmd_wr;
         pclr_ff <= cmd_wr && sub == `WML_CMD_PEAK_CLR;
         rclr_ff <= cmd_wr && sub == `WML_CMD_RAIN_CLR;
         mux_ff.chan   <= sub;
         mux_ff.en_one <= req_i.req && blk == `WML_BLK_ANA1;
         mux_ff.en_two <= req_i.req && blk == `WML_BLK_ANA2;
      end
   end

   assign mon_data_o             = data_ff;
   assign analog_sample_enable_o = ana_ff;
   assign bank_select_o          = bank_ff;
   assign device_acknowledge_o   = ack_ff;
   assign mux_o                  = mux_ff;
   assign peak_clr_o             = pclr_ff;
   assign rain_clr_o             = rclr_ff;

   sequence wind_rd_s;
      mon_rd && sub == `WML_MON_WIND;
   endsequence
   wind_word_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wind_rd_s |=> data_ff == {$past(peak_ff), $past(speed_ff)})
      else $error("wind word wrong");
   peak_keep_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wind_valid_i && !cmd_wr |=> peak_ff >= $past(wind_speed_i))
      else $error("peak below new sample");
   peak_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      cmd_wr && sub == `WML_CMD_PEAK_CLR && !wind_valid_i |=> peak_ff == 8'h00)
      else $error("peak not cleared");
   rain_step_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rain_pulse && !cmd_wr |=> rain_ff == $past(rain_ff) + 16'h0001)
      else $error("rain count missed");
   rain_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      cmd_wr && sub == `WML_CMD_RAIN_CLR && !rain_pulse |=> rain_ff == 16'h0000)
      else $error("rain not cleared");
   ana_enable_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      req_i.req && blk < 5'h03 |=> ana_ff)
      else $error("analog enable missing");
   bank_sel_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      req_i.req && blk == `WML_BLK_ANA0 |=> !bank_ff)
      else $error("bank select wrong");
   ack_digital_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ack_ff |-> $past(req_i.req) && ($past(blk) == 5'h03 || $past(blk) == 5'h04))
      else $error("stray acknowledge");
   mux_one_hot_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !(mux_ff.en_one && mux_ff.en_two))
      else $error("both muxes enabled");
   ident_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mon_rd && sub == `WML_MON_IDENT |=> data_ff[7:0] == TYPE_CODE)
      else $error("type code wrong");

   // A write into the monitor block must stay silent, or the host would take stale data.
   sequence ser_rd_s;
      mon_rd && sub == `WML_MON_SERIAL;
   endsequence
   sequence mon_wr_s;
      req_i.req && !req_i.rd && blk == `WML_BLK_MON;
   endsequence
   serial_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ser_rd_s |=> data_ff == {8'h00, $past(serial_ff)})
      else $error("serial number wrong");
   mon_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mon_wr_s |=> !ack_ff)
      else $error("monitor write acknowledged");
   mux_chan_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      req_i.req |=> mux_ff.chan == $past(sub))
      else $error("mux channel wrong");
   mux_one_src_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mux_ff.en_one |-> $past(req_i.req) && $past(blk) == `WML_BLK_ANA1)
      else $error("first mux stray enable");
   mux_two_src_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mux_ff.en_two |-> $past(req_i.req) && $past(blk) == `WML_BLK_ANA2)
      else $error("second mux stray enable");
endmodule

/* File: verif/weather_monitor_logic_tb_top.sv */
// Self-checking bench for the weather monitor logic top.
// Assumes the host model's one-cycle request and the short debounce parameter.
`timescale 1ns/10ps
module weather_monitor_logic_tb_top;
   localparam int         DEB  = 4;
   localparam logic [7:0] CODE = 8'h3c; // Arbitrary type code for this run.
   logic              sys_clk, srst, wind_valid, rain_n, ana_en, bank, ack, pclr, rclr;
   logic [7:0]        hdr, speed, peak, e;
   logic [15:0]       mon, rain;
   wml_pkg::wml_req_t req;
   wml_pkg::wml_mux_t mux;
   int                errors, checks_done, cycles, seed, i;
   wml_host_model i_wml_host_model (.sys_clk_i(sys_clk), .req_o(req));
   wml_top #(.DEBOUNCE_CYC(DEB), .TYPE_CODE(CODE)) i_wml_top (
      .sys_clk_i(sys_clk), .srst_i(srst), .req_i(req), .serial_link_header_i(hdr),
      .wind_speed_i(speed), .wind_valid_i(wind_valid), .rain_contact_n_i(rain_n),
      .mon_data_o(mon), .analog_sample_enable_o(ana_en), .bank_select_o(bank),
      .device_acknowledge_o(ack), .mux_o(mux), .peak_clr_o(pclr), .rain_clr_o(rclr));
   // Free-running clock at 10 MHz.
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // Cuts a hang short; the ceiling is about ten times the roughly five hundred cycles needed.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles >= 5000)
      begin
         errors++;
         test_done();
      end
   end
   task automatic test_done();
      if (errors == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Expected decode: analog, bank, acknowledge, both enables, channel for on-board blocks.
   function automatic logic [7:0] dec(input logic rd, input logic [7:0] a);
      logic [4:0] b;
      b = a[7:3];
      dec = {b < 5'h03, b == 5'h01 || b == 5'h02, (b == 5'h03 && rd) || (b == 5'h04 && !rd),
             b == 5'h01, b == 5'h02, (b == 5'h01 || b == 5'h02) ? a[2:0] : 3'h0};
   endfunction
   task automatic rd_mon(input logic [7:0] a, input logic [15:0] exp);
      i_wml_host_model.issue(1'b1, a);
      check({ack, mon}, {1'b1, exp});
   endtask
   // Each contact change arrives with one-cycle bounces, each shorter than the debounce window.
   task automatic settle(input logic lvl);
      repeat (3)
      begin
         @(posedge sys_clk) rain_n <= lvl;
         @(posedge sys_clk) rain_n <= ~lvl;
      end
      @(posedge sys_clk) rain_n <= lvl;
      repeat (DEB + 8) @(posedge sys_clk);
   endtask
   task automatic sample(input logic [7:0] s);
      @(posedge sys_clk);
      speed <= s;
      wind_valid <= 1'b1;
      @(posedge sys_clk);
      wind_valid <= 1'b0;
      if (s > peak)
         peak = s;
   endtask
   initial
   begin
      seed = 62;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      srst = 1'b1;
      hdr = 8'hff;
      speed = 8'h00;
      wind_valid = 1'b0;
      rain_n = 1'b1;
      peak = 8'h00;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      #1;
      check({6'h00, ana_en, bank, ack, pclr, rclr, mux}, 16'h0000);
      rd_mon(8'h1e, 16'h0000);
      // Link header: all cut, all closed, then random patterns.
      for (i = 0; i < 4; i++)
      begin
         @(posedge sys_clk) hdr <= (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
         repeat (5) @(posedge sys_clk);
         rd_mon(8'h1c, {8'h00, hdr});
      end
      rd_mon(8'h18, {8'h00, CODE});
      rd_mon(8'h19, 16'h0000);
      for (i = 0; i < 12; i++)
      begin
         sample(8'($random(seed)));
         rd_mon(8'h1e, {peak, speed});
      end
      i_wml_host_model.issue(1'b0, 8'h23);
      check({ack, pclr}, 2'b11);
      peak = 8'h00;
      rd_mon(8'h1e, {8'h00, speed});
      sample(8'h07);
      rd_mon(8'h1e, 16'h0707);
      rain = 16'h0000;
      for (i = 0; i < 5; i++)
      begin
         settle(1'b0);
         settle(1'b1);
         rain++;
         rd_mon(8'h1f, rain);
      end
      i_wml_host_model.issue(1'b0, 8'h24);
      check({ack, rclr}, 2'b11);
      rd_mon(8'h1f, 16'h0000);
      // Every address of the five blocks in both directions.
      for (i = 0; i < 80; i++)
      begin
         e = dec(i[0], 8'(i >> 1));
         i_wml_host_model.issue(i[0], 8'(i >> 1));
         check({ana_en, bank, ack, mux.en_one, mux.en_two, (e[4] || e[3]) ? mux.chan : 3'h0}, e);
      end
      test_done();
   end
endmodule

/* File: verif/wml_host_model.sv */
// Host interface board model: issues one addressed request at a time.
// Assumes the bench calls issue() and samples the answer once it returns.
`timescale 1ns/10ps
module wml_host_model (
   input  wire logic         sys_clk_i, // System clock.
   output wml_pkg::wml_req_t req_o      // Request toward the monitor logic.
);
   initial req_o = '0;
   // Released lines show the inverse of the last request, so a stale value never matches.
   task automatic issue(input logic rd, input logic [7:0] addr);
      @(posedge sys_clk_i);
      req_o <= '{req: 1'b1, rd: rd, addr: addr};
      @(posedge sys_clk_i);
      req_o <= '{req: 1'b0, rd: ~rd, addr: ~addr};
      #1;
   endtask
endmodule
